// File: logic/psl_pkg.sv
/*
 * psl_pkg: constants shared by the polling snapshot and log pointer block.
 * Assumes a single 100 MHz system clock and an active-low asynchronous reset.
 */
package psl_pkg;
    // ==========================================================
    // control register trigger
    localparam logic [15:0] PSL_POLL_TRIGGER = 16'h4E20; // decimal 20000

    // ==========================================================
    // widths and reset values
    localparam int PSL_DW = 32;
    localparam logic [31:0] PSL_PTR_START = 32'h0000_0001;
    localparam logic [31:0] PSL_ZERO = 32'h0000_0000;
    localparam logic [31:0] PSL_INTV_MAX_DEF = 32'h0000_0F00;
    localparam logic [31:0] PSL_DAILY_MAX_DEF = 32'h0000_0300;
    localparam logic [31:0] PSL_EVENT_MAX_DEF = 32'h0000_0400;

    // ==========================================================
    // unit conversion: scale is unsigned 16.16 fixed point
    localparam int PSL_SCALE_FRAC = 16;
    localparam logic [1:0] PSL_UNIT_BASE = 2'h0;

    // ==========================================================
    // flow calculation parameter slots
    localparam int PSL_SLOTS = 16;
    localparam int PSL_SLOT_AW = 4;
    // bit i set: slot i+1 reserved under the turbine method (slots 5-9, 12-14, 16)
    localparam logic [15:0] PSL_TURB_RSVD = 16'hB9F0;

    typedef enum logic [1:0] {
        PSL_CALC_ORIFICE,
        PSL_CALC_ISO,
        PSL_CALC_CONE,
        PSL_CALC_TURBINE
    } psl_method_t;
endpackage : psl_pkg

// File: logic/psl_polling_log.sv
/*
 * psl_polling_log: polling snapshot registers, log pointers, unit views and
 * method-dependent parameter slots of a flow computer register bank.
 * Assumes all inputs synchronous to sys_clk_in; the bus decode lives outside.
 */
`timescale 1ns/1ps
module psl_polling_log #(
    parameter logic [31:0] INTV_MAX = psl_pkg::PSL_INTV_MAX_DEF,
    parameter logic [31:0] DAILY_MAX = psl_pkg::PSL_DAILY_MAX_DEF,
    parameter logic [31:0] EVENT_MAX = psl_pkg::PSL_EVENT_MAX_DEF
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // control register write
    input wire logic ctrl_wr_in,
    input wire logic [15:0] ctrl_wdata_in,
    // accumulation samples
    input wire logic acc_valid_in,
    input wire logic [31:0] acc_volume_in,
    input wire logic [31:0] acc_value_in,
    input wire logic [31:0] acc_time_in,
    // unit settings
    input wire logic [1:0] unit_sel_in,
    input wire logic [31:0] unit_scale_in,
    input wire logic [31:0] unit_offset_in,
    // new log record strobes
    input wire logic intv_rec_in,
    input wire logic daily_rec_in,
    input wire logic event_rec_in,
    // parameter slots
    input wire psl_pkg::psl_method_t method_in,
    input wire logic prm_wr_in,
    input wire logic [3:0] prm_wr_slot_in,
    input wire logic [31:0] prm_wdata_in,
    input wire logic [3:0] prm_rd_slot_in,
    output logic [31:0] prm_rd_data_out,
    // polling views
    output logic [31:0] poll_index_out,
    output logic [31:0] cur_volume_out,
    output logic [31:0] cur_value_sum_out,
    output logic [31:0] cur_samples_out,
    output logic [31:0] cur_time_out,
    output logic [31:0] prev_volume_base_out,
    output logic [31:0] prev_volume_conf_out,
    output logic [31:0] prev_value_sum_out,
    output logic [31:0] prev_samples_out,
    output logic [31:0] prev_time_out,
    output logic poll_done_out,
    // log pointers and logged data
    output logic [31:0] intv_ptr_out,
    output logic [31:0] daily_ptr_out,
    output logic [31:0] event_ptr_out,
    output logic [31:0] log_volume_out
);
    import psl_pkg::*;

    logic poll_trig;
    logic [31:0] conf_next;
    logic [63:0] scaled;
    logic [31:0] mem_rd;
    logic [3:0] rd_slot_reg;
    psl_method_t rd_method_reg;

    // ==========================================================
    // trigger decode
    function automatic logic psl_is_trigger(input logic wr, input logic [15:0] data);
        return wr && (data == PSL_POLL_TRIGGER);
    endfunction : psl_is_trigger

    assign poll_trig = psl_is_trigger(ctrl_wr_in, ctrl_wdata_in);

    // ==========================================================
    // current accumulators: a sample in the trigger cycle opens the new period
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cur_volume_out <= PSL_ZERO;
            cur_value_sum_out <= PSL_ZERO;
            cur_samples_out <= PSL_ZERO;
            cur_time_out <= PSL_ZERO;
        end else if (poll_trig) begin
            cur_volume_out <= acc_valid_in ? acc_volume_in : PSL_ZERO;
            cur_value_sum_out <= acc_valid_in ? acc_value_in : PSL_ZERO;
            cur_samples_out <= acc_valid_in ? PSL_PTR_START : PSL_ZERO;
            cur_time_out <= acc_valid_in ? acc_time_in : PSL_ZERO;
        end else if (acc_valid_in) begin
            cur_volume_out <= cur_volume_out + acc_volume_in;
            cur_value_sum_out <= cur_value_sum_out + acc_value_in;
            cur_samples_out <= cur_samples_out + PSL_PTR_START;
            cur_time_out <= cur_time_out + acc_time_in;
        end
    end

    // ==========================================================
    // configured-unit conversion of the current volume
    always_comb begin
        scaled = {32'h0000_0000, cur_volume_out} * {32'h0000_0000, unit_scale_in};
        if (unit_sel_in == PSL_UNIT_BASE) begin
            conf_next = cur_volume_out;
        end else begin
            conf_next = scaled[PSL_SCALE_FRAC +: 32] + unit_offset_in;
        end
    end

    // previous polling snapshot and index
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_volume_base_out <= PSL_ZERO;
            prev_volume_conf_out <= PSL_ZERO;
            prev_value_sum_out <= PSL_ZERO;
            prev_samples_out <= PSL_ZERO;
            prev_time_out <= PSL_ZERO;
            poll_index_out <= PSL_ZERO;
            poll_done_out <= 1'b0;
        end else begin
            poll_done_out <= poll_trig;
            if (poll_trig) begin
                prev_volume_base_out <= cur_volume_out;
                prev_volume_conf_out <= conf_next;
                prev_value_sum_out <= cur_value_sum_out;
                prev_samples_out <= cur_samples_out;
                prev_time_out <= cur_time_out;
                poll_index_out <= poll_index_out + PSL_PTR_START;
            end
        end
    end

    // ==========================================================
    // log pointers
    function automatic logic [31:0] psl_ptr_step(input logic [31:0] ptr, input logic [31:0] max);
        return (ptr >= max) ? PSL_PTR_START : ptr + PSL_PTR_START;
    endfunction : psl_ptr_step

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            intv_ptr_out <= PSL_PTR_START;
            daily_ptr_out <= PSL_PTR_START;
            event_ptr_out <= PSL_PTR_START;
        end else begin
            if (intv_rec_in) begin
                intv_ptr_out <= psl_ptr_step(intv_ptr_out, INTV_MAX);
            end
            if (daily_rec_in) begin
                daily_ptr_out <= psl_ptr_step(daily_ptr_out, DAILY_MAX);
            end
            if (event_rec_in) begin
                event_ptr_out <= psl_ptr_step(event_ptr_out, EVENT_MAX);
            end
        end
    end

    // logged volume captured in base units on any new record
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            log_volume_out <= PSL_ZERO;
        end else if (intv_rec_in || daily_rec_in || event_rec_in) begin
            log_volume_out <= cur_volume_out;
        end
    end

    // ==========================================================
    // parameter slots: memory read then method mask
    psl_slot_mem #(
        .DW(PSL_DW),
        .AW(PSL_SLOT_AW)
    ) u_slot_mem (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .wr_in(prm_wr_in),
        .wr_addr_in(prm_wr_slot_in),
        .wr_data_in(prm_wdata_in),
        .rd_addr_in(prm_rd_slot_in),
        .rd_data_out(mem_rd)
    );

    // slot number and method follow the memory latency
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_slot_reg <= 4'h0;
            rd_method_reg <= PSL_CALC_ORIFICE;
        end else begin
            rd_slot_reg <= prm_rd_slot_in;
            rd_method_reg <= method_in;
        end
    end

    // reserved slots of the turbine method read as zero
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prm_rd_data_out <= PSL_ZERO;
        end else if (rd_method_reg == PSL_CALC_TURBINE && PSL_TURB_RSVD[rd_slot_reg]) begin
            prm_rd_data_out <= PSL_ZERO;
        end else begin
            prm_rd_data_out <= mem_rd;
        end
    end

    // ==========================================================
    // checks
    chk_trig_index: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        poll_trig |=> poll_index_out == $past(poll_index_out) + 32'h0000_0001)
        else $error("polling index did not step on trigger");
    chk_other_value: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (ctrl_wr_in && ctrl_wdata_in != 16'h4E20) |=> $stable(poll_index_out))
        else $error("non-trigger value started polling");
    chk_snapshot_copy: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        poll_trig |=> prev_volume_base_out == $past(cur_volume_out) && prev_time_out == $past(cur_time_out))
        else $error("previous polling copy wrong");
    chk_accum_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (poll_trig && !acc_valid_in) |=> cur_volume_out == 32'h0 && cur_samples_out == 32'h0)
        else $error("accumulators not cleared");
    chk_accum_add: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (acc_valid_in && !poll_trig) |=> cur_time_out == $past(cur_time_out) + $past(acc_time_in))
        else $error("run time not accumulated");
    chk_base_view: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (poll_trig && unit_sel_in == 2'h0) |=> prev_volume_conf_out == prev_volume_base_out)
        else $error("base selection altered the configured view");
    chk_intv_wrap: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (intv_rec_in && intv_ptr_out >= INTV_MAX) |=> intv_ptr_out == 32'h1)
        else $error("interval pointer failed to wrap");
    chk_daily_step: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (daily_rec_in && daily_ptr_out < DAILY_MAX) |=> daily_ptr_out == $past(daily_ptr_out) + 32'h1)
        else $error("daily pointer did not step");
    chk_ptr_range: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        event_ptr_out != 32'h0 && intv_ptr_out != 32'h0 && daily_ptr_out != 32'h0)
        else $error("log pointer reached zero");
    chk_slot_rsvd: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (method_in == PSL_CALC_TURBINE && prm_rd_slot_in == 4'h4) ##2 1'b1 |-> prm_rd_data_out == 32'h0)
        else $error("reserved turbine slot not zero");

    cov_poll: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) poll_trig ##1 poll_trig);
    cov_poll_acc: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) poll_trig && acc_valid_in);
    cov_wrap: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        event_rec_in && event_ptr_out >= EVENT_MAX);
    cov_turbine: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        rd_method_reg == PSL_CALC_TURBINE);
endmodule : psl_polling_log

// File: logic/psl_slot_mem.sv
/*
 * psl_slot_mem: small memory for the flow calculation parameter slots.
 * Assumes one write port and one read port on the system clock; read data registered.
 */
`timescale 1ns/1ps
module psl_slot_mem #(
    parameter int DW = 32,
    parameter int AW = 4
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // write port
    input wire logic wr_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [DW-1:0] wr_data_in,
    // read port
    input wire logic [AW-1:0] rd_addr_in,
    output logic [DW-1:0] rd_data_out
);
    logic [DW-1:0] mem_reg [0:(1<<AW)-1];

    // ==========================================================
    // storage, no reset needed for the array
    always_ff @(posedge sys_clk_in) begin
        if (wr_in) begin
            mem_reg[wr_addr_in] <= wr_data_in;
        end
    end

    // registered read
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out <= '0;
        end else begin
            rd_data_out <= mem_reg[rd_addr_in];
        end
    end
endmodule : psl_slot_mem

// File: testbench/psl_host_model.sv
/*
 * psl_host_model: host master that writes the control register.
 * Assumes the bench calls write_ctrl by hierarchical name; drives just after posedge.
 */
`timescale 1ns/1ps
module psl_host_model (
    // clock
    input wire logic sys_clk_in,
    // control register write
    output logic ctrl_wr_out,
    output logic [15:0] ctrl_wdata_out
);
    initial begin
        ctrl_wr_out = 1'b0;
        ctrl_wdata_out = 16'h0000;
    end

    // ==========================================================
    // hold strobe and data for n edges, then release
    task automatic write_ctrl(input logic [15:0] val, input int n);
        ctrl_wdata_out = val;
        ctrl_wr_out = 1'b1;
        repeat (n) begin
            @(posedge sys_clk_in);
            #1;
        end
        ctrl_wr_out = 1'b0;
        ctrl_wdata_out = ~val; // released data no longer shows the value
    endtask : write_ctrl
endmodule : psl_host_model

// File: testbench/psl_polling_log_bench.sv
/*
 * psl_polling_log_bench: self-checking bench for the polling and log pointer block.
 * Assumes psl_pkg and psl_host_model compiled first; record maximum shrunk to 4.
 */
`timescale 1ns/1ps
`define CHK(got, exp) check_val(got, exp);
module psl_polling_log_bench;
    import psl_pkg::*;
    localparam logic [31:0] MAX_REC = 32'h0000_0004;
    logic sys_clk, rst_n, ctrl_wr, acc_valid, intv_rec, daily_rec, event_rec, prm_wr, poll_done;
    logic [15:0] ctrl_wdata;
    logic [1:0] unit_sel;
    logic [3:0] prm_wr_slot, prm_rd_slot;
    logic [31:0] acc_volume, acc_value, acc_time, unit_scale, unit_offset, prm_wdata, prm_rd_data;
    logic [31:0] poll_index, cur_volume, cur_value_sum, cur_samples, cur_time, prev_volume_base;
    logic [31:0] prev_volume_conf, prev_value_sum, prev_samples, prev_time, intv_ptr, daily_ptr;
    logic [31:0] event_ptr, log_volume;
    psl_method_t method;
    int miscompares = 0;
    int comparisons = 0;

    psl_polling_log #(.INTV_MAX(MAX_REC), .DAILY_MAX(MAX_REC), .EVENT_MAX(MAX_REC)) uut (
        .sys_clk_in(sys_clk), .rst_n_in(rst_n), .ctrl_wr_in(ctrl_wr), .ctrl_wdata_in(ctrl_wdata),
        .acc_valid_in(acc_valid), .acc_volume_in(acc_volume), .acc_value_in(acc_value),
        .acc_time_in(acc_time), .unit_sel_in(unit_sel), .unit_scale_in(unit_scale),
        .unit_offset_in(unit_offset), .intv_rec_in(intv_rec), .daily_rec_in(daily_rec),
        .event_rec_in(event_rec), .method_in(method), .prm_wr_in(prm_wr), .prm_wr_slot_in(prm_wr_slot),
        .prm_wdata_in(prm_wdata), .prm_rd_slot_in(prm_rd_slot), .prm_rd_data_out(prm_rd_data),
        .poll_index_out(poll_index), .cur_volume_out(cur_volume), .cur_value_sum_out(cur_value_sum),
        .cur_samples_out(cur_samples), .cur_time_out(cur_time), .prev_volume_base_out(prev_volume_base),
        .prev_volume_conf_out(prev_volume_conf), .prev_value_sum_out(prev_value_sum),
        .prev_samples_out(prev_samples), .prev_time_out(prev_time), .poll_done_out(poll_done),
        .intv_ptr_out(intv_ptr), .daily_ptr_out(daily_ptr), .event_ptr_out(event_ptr),
        .log_volume_out(log_volume)
    );

    psl_host_model host (.sys_clk_in(sys_clk), .ctrl_wr_out(ctrl_wr), .ctrl_wdata_out(ctrl_wdata));

    // ==========================================================
    // clock and helpers
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val

    task automatic sample(input logic [31:0] vol, input logic [31:0] val, input logic [31:0] tim);
        acc_valid = 1'b1;
        acc_volume = vol;
        acc_value = val;
        acc_time = tim;
        tick();
    endtask : sample

    task automatic record(input int k);
        intv_rec = (k == 0);
        daily_rec = (k == 1);
        event_rec = (k == 2);
        tick();
    endtask : record

    function automatic logic [31:0] ptr_of(input int k);
        return (k == 0) ? intv_ptr : (k == 1) ? daily_ptr : event_ptr;
    endfunction : ptr_of

    task automatic finish_test();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    // ==========================================================
    // watchdog: whole run needs well under 1000 cycles
    initial begin
        #100000;
        miscompares++;
        finish_test();
    end

    // ==========================================================
    // main test sequence
    initial begin
        logic [31:0] exp_ptr;
        logic [63:0] prod;
        rst_n = 1'b0;
        {acc_valid, intv_rec, daily_rec, event_rec, prm_wr} = 5'h00;
        {acc_volume, acc_value, acc_time, unit_offset, prm_wdata} = '0;
        unit_sel = 2'h0;
        unit_scale = 32'h0001_0000;
        prm_wr_slot = 4'h0;
        prm_rd_slot = 4'h0;
        method = PSL_CALC_ORIFICE;
        repeat (6) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        `CHK(poll_index, 32'h0000_0000)
        tick();
        // accumulate two samples, then two refused control values
        sample(32'h0000_0010, 32'h0000_0007, 32'h0000_0003);
        sample(32'h0000_0020, 32'h0000_0009, 32'h0000_0005);
        acc_valid = 1'b0;
        `CHK(cur_volume, 32'h0000_0030)
        `CHK(cur_value_sum, 32'h0000_0010)
        `CHK(cur_samples, 32'h0000_0002)
        `CHK(cur_time, 32'h0000_0008)
        host.write_ctrl(16'h4E1F, 1);
        tick();
        host.write_ctrl(16'h4E21, 1);
        `CHK(poll_index, 32'h0000_0000)
        `CHK(cur_volume, 32'h0000_0030)
        $display("test accumulate done");
        // log pointers advance and wrap; log data stays in base units
        unit_sel = 2'h1;
        unit_scale = 32'h0002_0000;
        unit_offset = 32'h0000_0005;
        for (int k = 0; k < 3; k++) begin
            `CHK(ptr_of(k), 32'h0000_0001)
            exp_ptr = 32'h0000_0001;
            for (int n = 0; n < 6; n++) begin
                record(k);
                exp_ptr = (exp_ptr >= MAX_REC) ? 32'h0000_0001 : exp_ptr + 32'h0000_0001;
                `CHK(ptr_of(k), exp_ptr)
            end
            {intv_rec, daily_rec, event_rec} = 3'h0;
            tick();
            `CHK(log_volume, 32'h0000_0030)
        end
        $display("test pointers done");
        // polling trigger: snapshot, index, clear, both views
        prod = 64'h0000_0000_0000_0030 * 64'(unit_scale);
        host.write_ctrl(PSL_POLL_TRIGGER, 1);
        `CHK(32'(poll_done), 32'h0000_0001)
        `CHK(prev_volume_base, 32'h0000_0030)
        `CHK(prev_volume_conf, prod[47:16] + 32'h0000_0005)
        `CHK(prev_value_sum, 32'h0000_0010)
        `CHK(prev_samples, 32'h0000_0002)
        `CHK(prev_time, 32'h0000_0008)
        `CHK(poll_index, 32'h0000_0001)
        `CHK(cur_volume | cur_value_sum | cur_samples | cur_time, 32'h0000_0000)
        tick();
        `CHK(32'(poll_done), 32'h0000_0000)
        host.write_ctrl(PSL_POLL_TRIGGER, 2);
        `CHK(poll_index, 32'h0000_0003)
        `CHK(prev_volume_base, 32'h0000_0000)
        // base selection, with a sample in the trigger cycle opening the new period
        unit_sel = 2'h0;
        sample(32'h0000_0040, 32'h0000_0001, 32'h0000_0002);
        host.write_ctrl(PSL_POLL_TRIGGER, 1);
        acc_valid = 1'b0;
        `CHK(prev_volume_conf, 32'h0000_0040)
        `CHK(prev_volume_base, 32'h0000_0040)
        `CHK(cur_volume, 32'h0000_0040)
        `CHK(cur_samples, 32'h0000_0001)
        `CHK(poll_index, 32'h0000_0004)
        $display("test polling done");
        // parameter slots under every method
        for (int s = 0; s < PSL_SLOTS; s++) begin
            prm_wr = 1'b1;
            prm_wr_slot = 4'(s);
            prm_wdata = 32'h0000_A000 + 32'(s);
            tick();
        end
        prm_wr = 1'b0;
        for (int m = 0; m < 4; m++) begin
            method = psl_method_t'(m[1:0]);
            for (int s = 0; s < PSL_SLOTS; s++) begin
                prm_rd_slot = 4'(s);
                tick();
                tick();
                `CHK(prm_rd_data, (m == 3 && PSL_TURB_RSVD[s]) ? 32'h0 : 32'h0000_A000 + 32'(s))
            end
        end
        $display("test slots done");
        finish_test();
    end
endmodule : psl_polling_log_bench
